// ==== core/abc_burst_track.sv ====
// Slave-side burst tracker: decodes control, predicts addresses, flags early termination
//Behaviour
// R1: Burst field values 000..111 mean SINGLE, INCR, WRAP4, INCR4, WRAP8, INCR8, WRAP16, INCR16.
// R2: Wrapping bursts wrap beat addresses at size-in-bytes times beats (master's duty).
// R3: Incrementing beats add the size in bytes to the last address (master's duty).
// R4: A burst never crosses a 1kB boundary (master's duty).
// R5: An INCR burst may hold any number of beats, even one.
// R6: Every beat is aligned to its own size (master's duty).
// R7: After a burst starts only SEQ or BUSY may follow; NONSEQ or IDLE ends it early.
// R8: A master that loses the bus finishes the rest as an INCR burst (master's duty).
// R9: Control stays constant through a burst and is timed with the address (master's duty).
// R10: Writes carry data on the write bus; reads get data from the slave on the read bus.
// R11: Size field gives 8 times two to the field value bits per beat.
// R12: The wrap boundary comes from the size field and the burst beat count.
// R13: Protection bits: 0 data/opcode, 1 privileged/user, 2 bufferable, 3 cacheable.
// R14: Protection bits are ignored unless software enables their use.
// R15: Transfer type 00 IDLE, 01 BUSY, 10 NONSEQ, 11 SEQ.
// R16: During BUSY the master already shows the next beat's address and control.
// R17: Tracking state moves only while HREADY is high and clears on reset.
`default_nettype none
module abc_burst_track
	import abc_pkg::*;
#(
	parameter int BEAT_W = 5
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	// Bus side (address phase sampled while HREADY high, plus write and read data)
	input  wire abc_addr_t         bus_ap,
	input  wire logic              hsel,
	input  wire logic              hready,
	input  wire logic [DATA_W-1:0] hwdata,
	output logic [DATA_W-1:0]      hrdata,
	// User side
	output abc_beat_t              beat_q,
	output logic [DATA_W-1:0]      wdata,
	input  wire logic [DATA_W-1:0] rdata,
	output logic                   early_term_q,
	output logic                   addr_err_q,
	// Register port
	input  wire logic [3:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [31:0]            reg_rdata
);
	abc_state_t        state_q, state_d;
	logic [ADDR_W-1:0] next_q;
	logic [BEAT_W-1:0] left_q;
	abc_burst_t        burst_q;
	logic [2:0]        size_q;
	logic              write_q;
	logic [2:0]        ctrl_q;
	logic [15:0]       term_cnt_q;
	logic [15:0]       mis_cnt_q;

	wire take     = hready && hsel;
	wire is_seq   = bus_ap.trans == TRANS_SEQ;
	wire is_busy  = bus_ap.trans == TRANS_BUSY;
	wire is_nseq  = bus_ap.trans == TRANS_NONSEQ;
	wire active   = take && (is_seq || is_nseq); // [R15]
	wire enabled  = ctrl_q[CTRL_EN_BIT];
	wire in_burst = state_q != TRK_IDLE;

	// Bytes per beat is 1 << size, so width is 8 << size bits [R11]
	wire [ADDR_W-1:0] step = ADDR_W'(1) << bus_ap.size;
	wire [4:0] beats = (bus_ap.burst == BURST_WRAP4 || bus_ap.burst == BURST_INCR4) ? 5'h04 :
		(bus_ap.burst == BURST_WRAP8 || bus_ap.burst == BURST_INCR8) ? 5'h08 :
		(bus_ap.burst == BURST_WRAP16 || bus_ap.burst == BURST_INCR16) ? 5'h10 : 5'h01; // [R1]
	wire is_wrap  = !bus_ap.burst[0] && bus_ap.burst != BURST_SINGLE;
	wire fixed    = bus_ap.burst != BURST_INCR; // [R5]
	// Wrap span is bytes per beat times beat count, as a mask [R12]
	wire [ADDR_W-1:0] span  = step * ADDR_W'(beats);
	wire [ADDR_W-1:0] inc   = bus_ap.addr + step;
	wire [ADDR_W-1:0] nxt_a = is_wrap ? ((bus_ap.addr & ~(span - ADDR_W'(1))) |
		(inc & (span - ADDR_W'(1)))) : inc; // [R2] [R3]
	wire misalign = active && ((bus_ap.addr & (step - ADDR_W'(1))) != '0); // [R6]
	// SEQ beat outside the 1kB page of the predicted address is a master fault the slave reports [R4]
	wire cross1k  = active && is_seq && in_burst &&
		(bus_ap.addr[ADDR_W-1:BOUND_1K_LSB] != next_q[ADDR_W-1:BOUND_1K_LSB]);
	// A SEQ that does not match the prediction or the frozen control also counts [R9]
	wire mismatch = active && is_seq && in_burst && (bus_ap.addr != next_q ||
		bus_ap.burst != burst_q || bus_ap.size != size_q || bus_ap.write != write_q);
	wire fixed_q_rem = (burst_q != BURST_INCR) && (left_q != '0);
	// NONSEQ or IDLE while beats remain ends the burst early [R7]
	wire early    = take && in_burst && fixed_q_rem && (is_nseq || bus_ap.trans == TRANS_IDLE);
	wire use_prot = ctrl_q[CTRL_USEPROT_BIT];

	always_comb begin
		state_d = state_q;
		case (state_q)
			TRK_IDLE:  if (active && is_nseq)
				state_d = (beats == 5'h01 && fixed) ? TRK_LAST : TRK_BURST;
			TRK_BURST: begin
				if (take && (is_nseq || bus_ap.trans == TRANS_IDLE))
					state_d = is_nseq ? TRK_BURST : TRK_IDLE; // [R7]
				else if (active && fixed_q_rem && left_q == BEAT_W'(1))
					state_d = TRK_LAST;
			end
			TRK_LAST:  if (take && !is_busy) state_d = (active && is_nseq) ? TRK_BURST : TRK_IDLE;
			default:   state_d = TRK_IDLE;
		endcase
		if (state_d == TRK_BURST && active && is_nseq && fixed && beats == 5'h01)
			state_d = TRK_LAST;
	end

	// Update only on HREADY high, clear on reset [R17]
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= TRK_IDLE;
			next_q  <= '0;
			left_q  <= '0;
			burst_q <= BURST_SINGLE;
			size_q  <= 3'h0;
			write_q <= 1'b0;
		end else if (enabled && hready) begin // [R17]
			state_q <= state_d;
			if (active) begin
				next_q <= nxt_a;
				if (is_nseq) begin
					left_q  <= BEAT_W'(beats - 5'h01);
					burst_q <= bus_ap.burst;
					size_q  <= bus_ap.size;
					write_q <= bus_ap.write;
				end else if (left_q != '0) begin
					left_q <= left_q - BEAT_W'(1);
				end
			end
		end
	end

	// Data phase beat record; BUSY and IDLE are ignored [R16]
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			beat_q       <= '0;
			early_term_q <= 1'b0;
			addr_err_q   <= 1'b0;
		end else if (hready) begin
			beat_q.valid     <= active && enabled;
			beat_q.first     <= is_nseq;
			beat_q.last      <= state_d == TRK_LAST || (state_d == TRK_IDLE && active);
			beat_q.write     <= bus_ap.write; // [R10]
			beat_q.addr      <= bus_ap.addr;
			beat_q.size      <= bus_ap.size;
			beat_q.data_acc  <= use_prot ? bus_ap.prot[PROT_DATA_BIT] : 1'b1; // [R13] [R14]
			beat_q.priv      <= use_prot && bus_ap.prot[PROT_PRIV_BIT];
			beat_q.bufable   <= use_prot && bus_ap.prot[PROT_BUF_BIT];
			beat_q.cacheable <= use_prot && bus_ap.prot[PROT_CACHE_BIT];
			early_term_q     <= enabled && early; // [R7]
			addr_err_q       <= enabled && (misalign || cross1k || mismatch);
		end
	end

	// Write data passes through, read data is held in a flop for the read bus [R10]
	assign wdata = hwdata;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			hrdata <= '0;
		else
			hrdata <= rdata;
	end

	// Counters saturate; below saturation a clear write loses to a same-cycle event
	wire clr = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_CLR_BIT];
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q     <= CTRL_RESET;
			term_cnt_q <= '0;
			mis_cnt_q  <= '0;
		end else begin
			if (reg_wr && reg_addr == REG_CTRL)
				ctrl_q <= {1'b0, reg_wdata[1:0]};
			if (hready && enabled && early && term_cnt_q != 16'hffff)
				term_cnt_q <= term_cnt_q + 16'h0001;
			else if (clr)
				term_cnt_q <= '0;
			if (hready && enabled && (misalign || cross1k || mismatch) && mis_cnt_q != 16'hffff)
				mis_cnt_q <= mis_cnt_q + 16'h0001;
			else if (clr)
				mis_cnt_q <= '0;
		end
	end

	wire [31:0] rd_mux = (reg_addr == REG_CTRL)   ? {29'h0, ctrl_q} :
		(reg_addr == REG_STATUS) ? {13'h0, state_q, {(16-BEAT_W){1'b0}}, left_q} :
		(reg_addr == REG_NEXT)   ? next_q :
		(reg_addr == REG_COUNT)  ? {term_cnt_q, mis_cnt_q} :
		(reg_addr == REG_CTRLS)  ? {24'h0, write_q, size_q, 1'b0, burst_q} : 32'h0;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= '0;
		else
			reg_rdata <= reg_rd ? rd_mux : 32'h0;
	end

	// Early termination flag must follow a fixed burst in TRK_BURST that sees NONSEQ or IDLE
	early_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(hready && enabled && take && state_q == TRK_BURST && fixed_q_rem && !is_busy && !is_seq)
		|=> early_term_q) else $error("early termination missed"); // [R7]
	no_move_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!hready |=> $stable(state_q) && $stable(left_q)) else $error("tracker moved on wait"); // [R17]
	count_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(enabled && hready && active && is_nseq && bus_ap.burst == BURST_INCR16)
		|=> left_q == BEAT_W'(15)) else $error("beat count wrong"); // [R1]
	wrap_pred_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(enabled && hready && active && bus_ap.burst == BURST_WRAP4 && bus_ap.size == 3'h2 &&
		bus_ap.addr[3:0] == 4'hc) |=> next_q[3:0] == 4'h0) else $error("wrap wrong"); // [R2] [R12]
	incr_pred_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(enabled && hready && active && bus_ap.burst == BURST_INCR8 && bus_ap.size == 3'h1)
		|=> next_q == $past(bus_ap.addr) + 32'h2) else $error("increment wrong"); // [R3] [R11]
	prot_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(hready && !use_prot) |=> !beat_q.priv && !beat_q.cacheable && beat_q.data_acc)
		else $error("protection not ignored"); // [R14]
	idle_valid_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(hready && !active) |=> !beat_q.valid) else $error("idle beat passed"); // [R15]
	align_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(hready && enabled && active && bus_ap.size == 3'h2 && bus_ap.addr[1:0] != 2'h0)
		|=> addr_err_q) else $error("misalign missed"); // [R6]
endmodule
`default_nettype wire

// ==== core/abc_pkg.sv ====
// Package: burst, transfer, tracker state and protection encodings for the burst tracker
`default_nettype none
package abc_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int BOUND_1K_LSB = 10;
	// Protection bit positions
	localparam int PROT_DATA_BIT = 0;
	localparam int PROT_PRIV_BIT = 1;
	localparam int PROT_BUF_BIT  = 2;
	localparam int PROT_CACHE_BIT = 3;
	// Register port offsets
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_NEXT   = 4'h2;
	localparam logic [3:0] REG_COUNT  = 4'h3;
	localparam logic [3:0] REG_CTRLS  = 4'h4;
	localparam logic [2:0] CTRL_RESET = 3'h1;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_USEPROT_BIT = 1;
	localparam int CTRL_CLR_BIT = 2;

	typedef enum logic [2:0] {
		BURST_SINGLE = 3'h0,
		BURST_INCR   = 3'h1,
		BURST_WRAP4  = 3'h2,
		BURST_INCR4  = 3'h3,
		BURST_WRAP8  = 3'h4,
		BURST_INCR8  = 3'h5,
		BURST_WRAP16 = 3'h6,
		BURST_INCR16 = 3'h7
	} abc_burst_t;

	typedef enum logic [1:0] {
		TRANS_IDLE   = 2'h0,
		TRANS_BUSY   = 2'h1,
		TRANS_NONSEQ = 2'h2,
		TRANS_SEQ    = 2'h3
	} abc_trans_t;

	typedef enum logic [2:0] {
		TRK_IDLE  = 3'b001,
		TRK_BURST = 3'b010,
		TRK_LAST  = 3'b100
	} abc_state_t;

	// Address-phase bundle as seen on the bus
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		abc_trans_t        trans;
		logic              write;
		logic [2:0]        size;
		abc_burst_t        burst;
		logic [3:0]        prot;
	} abc_addr_t;

	// Per-beat decode presented to the user logic
	typedef struct packed {
		logic              valid;
		logic              first;
		logic              last;
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [2:0]        size;
		logic              data_acc;
		logic              priv;
		logic              bufable;
		logic              cacheable;
	} abc_beat_t;
endpackage
`default_nettype wire

// ==== testbench/abc_master_model.sv ====
// Bus master model: drives address-phase bursts on the tracker's bus side
`default_nettype none
module abc_master_model
	import abc_pkg::*;
(
	// Bus
	input  wire logic         sys_clk,
	input  wire logic         hready,
	output abc_addr_t         bus_ap,
	output logic [DATA_W-1:0] hwdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		bus_ap = '0;
		hwdata = '0;
	end
	// A cut burst leaves the bus to the next NONSEQ with no IDLE between
	task automatic run(input abc_addr_t c, input int n, input int bsy, input bit cut);
		logic [ADDR_W-1:0] b;
		int                i;
		b = (32'h1 << c.size) * (2 << c.burst[2:1]);
		for (i = 0; i < n; i++) begin
			if (i == bsy && i > 0) begin
				c.trans = TRANS_BUSY;
				bus_ap <= c;
				do @(posedge sys_clk); while (!hready);
			end
			c.trans = (i > 0) ? TRANS_SEQ : TRANS_NONSEQ;
			bus_ap <= c;
			do @(posedge sys_clk); while (!hready);
			hwdata <= $urandom;
			if (c.burst[0] || c.burst == BURST_SINGLE)
				c.addr = c.addr + (32'h1 << c.size);
			else
				c.addr = (c.addr & ~(b - 1)) | ((c.addr + (32'h1 << c.size)) & (b - 1));
		end
		if (!cut) begin
			c.trans = TRANS_IDLE;
			bus_ap <= c;
			do @(posedge sys_clk); while (!hready);
		end
	endtask
endmodule
`default_nettype wire

// ==== testbench/test_ahb_burst_control.sv ====
// Self-checking bench for the slave-side burst tracker
`default_nettype none
module test_ahb_burst_control
	import abc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk = 0, rst_n = 0, hready = 0, hsel = 1, reg_wr = 0, reg_rd = 0;
	logic [31:0] hwdata, hrdata, wdata, rdata = 0, reg_wdata = 0, reg_rdata, rp;
	logic [3:0]  reg_addr = 0;
	logic [42:0] expq[$];
	int          n_early = 0, n_aerr = 0;
	abc_addr_t   bus_ap;
	abc_beat_t   beat;
	logic        early, aerr;
	int          bad_count = 0, checked = 0;
	bit          up = 0, rp_ok = 0;
	abc_burst_track u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_ap(bus_ap), .hsel(hsel),
		.hready(hready), .hwdata(hwdata), .hrdata(hrdata), .beat_q(beat), .wdata(wdata),
		.rdata(rdata), .early_term_q(early), .addr_err_q(aerr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	abc_master_model u_mst (.sys_clk(sys_clk), .hready(hready), .bus_ap(bus_ap), .hwdata(hwdata));
	always #25 sys_clk = ~sys_clk;
	// Random wait states stress the hold-while-not-ready path
	always @(posedge sys_clk) begin
		hready <= ($urandom % 4) != 0;
		rdata <= $urandom;
	end
	task automatic chk(input string nm, input logic [42:0] e, input logic [42:0] s);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	always @(posedge sys_clk) begin
		logic [42:0] e;
		if (rst_n) begin
			if (rp_ok)
				chk("hrdata", rp, hrdata);
			chk("wdata", hwdata, wdata);
			rp = rdata;
			rp_ok = 1;
			if (hready) begin
				n_early += (early === 1'b1);
				n_aerr += (aerr === 1'b1);
			end
			if (hready && beat.valid === 1'b1 && expq.size() > 0) begin
				e = expq.pop_front();
				chk("beat", e, {e[42], beat.first, beat.last & e[42], beat.write, beat.size,
					beat.cacheable, beat.bufable, beat.priv, beat.data_acc,
					beat.addr});
			end
		end
	end
	task automatic burst(input abc_burst_t bt, input logic [2:0] sz, input logic [31:0] a,
		input logic [3:0] pr, input int n, input int nr, input int bsy);
		abc_addr_t   c;
		logic [31:0] by, b, x;
		int          i;
		bit          w, cl, wr;
		by = 32'h1 << sz;
		b = by * (2 << bt[2:1]);
		w = !bt[0] && bt != BURST_SINGLE;
		cl = bt != BURST_INCR;
		wr = $urandom % 2;
		for (i = 0; i < nr; i++) begin
			x = w ? (a & ~(b - 1)) | ((a + i * by) & (b - 1)) : a + i * by;
			expq.push_back({cl, i == 0, cl && i == n - 1, wr, sz, up ? pr : 4'h1, x});
		end
		c = '{addr: a, trans: TRANS_IDLE, write: wr, size: sz, burst: bt, prot: pr};
		u_mst.run(c, nr, bsy, nr < n);
	endtask
	task automatic rw(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge sys_clk);
		reg_wr <= 0;
		@(posedge sys_clk);
	endtask
	task automatic rr(input logic [3:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge sys_clk);
		reg_rd <= 0;
		@(posedge sys_clk);
		chk("reg", e, reg_rdata);
	endtask
	// Waits up to 200 cycles for the noted beats to show, then 4 more cycles to let counters land
	task automatic settle;
		for (int k = 0; k < 200 && expq.size() > 0; k++)
			@(posedge sys_clk);
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic tally_and_finish;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#2000000;
		bad_count++;
		tally_and_finish;
	end
	initial begin
		void'($urandom(32'hf143cbe3));
		repeat (5) @(posedge sys_clk);
		rst_n <= 1;
		@(posedge sys_clk);
		rr(REG_CTRL, 32'h1);
		rr(REG_STATUS, 32'h0001_0000);
		rr(4'hf, 32'h0);
		burst(BURST_WRAP4, 3'h2, 32'h34, 4'h0, 4, 4, 2);
		burst(BURST_WRAP8, 3'h2, 32'h34, 4'h0, 8, 8, 0);
		burst(BURST_WRAP16, 3'h0, 32'h3, 4'h0, 16, 16, 0);
		burst(BURST_INCR, 3'h1, 32'h20, 4'h0, 2, 2, 0);
		rw(REG_CTRL, 32'h3);
		up = 1;
		burst(BURST_INCR8, 3'h1, 32'h10, 4'hf, 8, 8, 3);
		burst(BURST_INCR16, 3'h0, 32'h40, 4'ha, 16, 16, 0);
		burst(BURST_INCR4, 3'h2, 32'h100, 4'h5, 4, 2, 0);
		burst(BURST_INCR, 3'h2, 32'h108, 4'h5, 2, 2, 0);
		burst(BURST_SINGLE, 3'h2, 32'h200, 4'h5, 1, 1, 0);
		settle;
		rr(REG_COUNT, 32'h0001_0000);
		burst(BURST_SINGLE, 3'h2, 32'h32, 4'h5, 1, 1, 0);
		settle;
		rr(REG_COUNT, 32'h0001_0001);
		chk("early_term", 43'h1, n_early);
		chk("addr_err", 43'h1, n_aerr);
		rw(REG_CTRL, 32'h7);
		rr(REG_COUNT, 32'h0);
		rr(REG_CTRL, 32'h3);
		chk("queue", 43'h0, expq.size());
		tally_and_finish;
	end
endmodule
`default_nettype wire
